// ### shared/ens_regs.svh
// Register offsets, field positions and reset values of the enable-pin assignment block
// Operation
// - An assigned linear regulator turns on while the enable pin is high (only in internal flops lin_on_q, at no output); all eight assign bits reset to 0.
// - An assigned linear regulator with the pin low is off if its sleep-keep bit is 0, else low-power.
// - Each linear regulator has one assign bit that selects pin control of its state.
// - An assigned switching supply takes state and voltage from the pin together with its sleep-keep bit.
// - With its assign bit at 0 the pin has no effect and the supply follows registers and device state.
// - Assigned external converter with pin high takes voltage or off from its active voltage register.
// - Assigned external converter with pin low takes voltage or off from its sleep voltage register.
// - Assigned external converter, pin low, keep bit 1 runs low-power unless its sleep voltage is off.
// - Assigned core 2 uses its active voltage with the pin high and its sleep voltage with it low.
// - Assigned core 2, pin low, sleep-keep 1 runs low-power unless its sleep voltage is off.
// - Assigned core 1 uses its active voltage with the pin high and its sleep voltage with it low.
// - Assigned core 1, pin low, sleep-keep 1 runs low-power unless its sleep voltage is off.
// - Assigned I/O converter is on whenever the pin is high.
// - Assigned I/O converter with the pin low is off, or low-power if its sleep-keep bit is 1.
// - Any assign bit set, except spare switching bit 4, disables the voltage-scaling serial function of the shared pins.
`ifndef ENS_REGS_SVH
`define ENS_REGS_SVH
`define ENS_LIN_ASSIGN_ADDR   12'h047
`define ENS_SW_ASSIGN_ADDR    12'h048
`define ENS_LIN_ASSIGN_RST    8'h00
`define ENS_SW_ASSIGN_RST     5'h00
`define ENS_SW_IO_BIT         0
`define ENS_SW_CORE1_BIT      1
`define ENS_SW_CORE2_BIT      2
`define ENS_SW_EXT_BIT        3
`define ENS_SW_SPARE_BIT      4
`define ENS_VSEL_OFF          8'h00
`endif

// ### shared/ens_pkg.sv
// Types of the enable-pin assignment block
package ens_pkg;
   typedef enum logic [1:0]
   {
      ENS_MODE_OFF = 2'h0,
      ENS_MODE_ON  = 2'h1,
      ENS_MODE_LP  = 2'h2
   } ens_mode_t;

   typedef struct packed
   {
      logic [7:0] lin_assign;
      logic [4:0] sw_assign;
   } ens_cfg_t;

   typedef struct packed
   {
      ens_cfg_t   cfg;
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
      logic [7:0]  lin_ctl;
      logic [7:0]  lin_lp;
      logic [3:0]  sw_ctl;
      logic [3:0]  sw_lp;
      logic [3:0]  sw_on;
      logic [7:0]  ext_v;
      logic [7:0]  core1_v;
      logic [7:0]  core2_v;
      logic        link_off;
   } ens_state_t;
endpackage

// ### verilog/ens_assign.sv
// Enable-pin supply assignment registers with APB slave and supply override logic
//
// Design decision made here: register access over APB.
`timescale 1ns/1ps
`include "ens_regs.svh"
module ens_assign
   import ens_pkg::*;
(
   // Clock and reset
   input  wire logic        MCLK_IN,
   input  wire logic        RSTN_IN,
   // APB slave
   input  wire logic        PSEL_IN,
   input  wire logic        PENABLE_IN,
   input  wire logic        PWRITE_IN,
   input  wire logic [11:0] PADDR_IN,
   input  wire logic [31:0] PWDATA_IN,
   input  wire logic [3:0]  PSTRB_IN,
   output logic      [31:0] PRDATA_OUT,
   output logic             PREADY_OUT,
   output logic             PSLVERR_OUT,
   // Enable pin and device settings
   input  wire logic        SECOND_ENABLE_INPUT_IN,
   input  wire logic [7:0]  SLEEP_KEEP_LINEAR_MASK_IN,
   input  wire logic [3:0]  SLEEP_KEEP_SWITCHER_MASK_IN,
   input  wire logic        EXTERNAL_CONVERTER_KEEP_BIT_IN,
   input  wire logic [7:0]  EXTERNAL_CONV_ACTIVE_VOLTAGE_IN,
   input  wire logic [7:0]  EXTERNAL_CONV_SLEEP_VOLTAGE_IN,
   input  wire logic [7:0]  CORE1_ACTIVE_VOLTAGE_IN,
   input  wire logic [7:0]  CORE1_SLEEP_VOLTAGE_IN,
   input  wire logic [7:0]  CORE2_ACTIVE_VOLTAGE_IN,
   input  wire logic [7:0]  CORE2_SLEEP_VOLTAGE_IN,
   // Supply overrides
   output logic      [7:0]  LIN_PIN_CTL_OUT,
   output logic      [7:0]  LIN_LP_OUT,
   output logic      [3:0]  SW_PIN_CTL_OUT,
   output logic      [3:0]  SW_ON_OUT,
   output logic      [3:0]  SW_LP_OUT,
   output logic      [7:0]  EXT_VSEL_OUT,
   output logic      [7:0]  CORE1_VSEL_OUT,
   output logic      [7:0]  CORE2_VSEL_OUT,
   output logic             SERIAL_LINK_OFF_OUT
);
   ens_state_t st_q;
   ens_state_t st_d;

   logic        pin;
   logic        acc;
   logic        wr_ok;
   logic [7:0]  keep_sw;
   logic [7:0]  vsel   [3];
   logic [7:0]  vact   [3];
   logic [7:0]  vslp   [3];
   logic [2:0]  keepv;
   logic [2:0]  asgv;

   assign pin   = SECOND_ENABLE_INPUT_IN;
   assign acc   = PSEL_IN && PENABLE_IN && !st_q.pready;
   assign wr_ok = PSTRB_IN[0];
   assign keep_sw = {4'h0, SLEEP_KEEP_SWITCHER_MASK_IN};
   assign vact[0] = EXTERNAL_CONV_ACTIVE_VOLTAGE_IN;
   assign vact[1] = CORE1_ACTIVE_VOLTAGE_IN;
   assign vact[2] = CORE2_ACTIVE_VOLTAGE_IN;
   assign vslp[0] = EXTERNAL_CONV_SLEEP_VOLTAGE_IN;
   assign vslp[1] = CORE1_SLEEP_VOLTAGE_IN;
   assign vslp[2] = CORE2_SLEEP_VOLTAGE_IN;
   assign keepv = {SLEEP_KEEP_SWITCHER_MASK_IN[`ENS_SW_CORE2_BIT],
                   SLEEP_KEEP_SWITCHER_MASK_IN[`ENS_SW_CORE1_BIT],
                   EXTERNAL_CONVERTER_KEEP_BIT_IN};

   always_comb
   begin
      st_d         = st_q;
      st_d.pready  = acc;
      st_d.pslverr = 1'b0;
      asgv = {st_q.cfg.sw_assign[`ENS_SW_CORE2_BIT],
              st_q.cfg.sw_assign[`ENS_SW_CORE1_BIT],
              st_q.cfg.sw_assign[`ENS_SW_EXT_BIT]};
      for (int i = 0; i < 3; i++)
      begin
         vsel[i] = pin ? vact[i] : vslp[i];
      end
      if (acc)
      begin
         st_d.prdata = 32'h0;
         case (PADDR_IN)
            `ENS_LIN_ASSIGN_ADDR:
            begin
               st_d.prdata = {24'h0, st_q.cfg.lin_assign};
               if (PWRITE_IN && wr_ok)
               begin
                  st_d.cfg.lin_assign = PWDATA_IN[7:0];
               end
            end
            `ENS_SW_ASSIGN_ADDR:
            begin
               st_d.prdata = {27'h0, st_q.cfg.sw_assign};
               if (PWRITE_IN && wr_ok)
               begin
                  st_d.cfg.sw_assign = PWDATA_IN[4:0];
               end
            end
            default:
            begin
               st_d.pslverr = 1'b1;
            end
         endcase
      end
      // Linear regulators
      st_d.lin_ctl = st_q.cfg.lin_assign;
      st_d.lin_lp  = st_q.cfg.lin_assign & {8{!pin}} & SLEEP_KEEP_LINEAR_MASK_IN;
      // Switching supplies: bit 0 io, 1 core1, 2 core2, 3 external
      st_d.sw_ctl = st_q.cfg.sw_assign[3:0];
      st_d.sw_on[`ENS_SW_IO_BIT] = st_q.cfg.sw_assign[`ENS_SW_IO_BIT] && pin;
      st_d.sw_lp[`ENS_SW_IO_BIT] = st_q.cfg.sw_assign[`ENS_SW_IO_BIT] && !pin
                                   && keep_sw[`ENS_SW_IO_BIT];
      st_d.sw_on[`ENS_SW_CORE1_BIT] = asgv[1] && (vsel[1] != `ENS_VSEL_OFF);
      st_d.sw_lp[`ENS_SW_CORE1_BIT] = asgv[1] && !pin && keepv[1]
                                      && (vsel[1] != `ENS_VSEL_OFF);
      st_d.sw_on[`ENS_SW_CORE2_BIT] = asgv[2] && (vsel[2] != `ENS_VSEL_OFF);
      st_d.sw_lp[`ENS_SW_CORE2_BIT] = asgv[2] && !pin && keepv[2]
                                      && (vsel[2] != `ENS_VSEL_OFF);
      st_d.sw_on[`ENS_SW_EXT_BIT] = asgv[0] && (vsel[0] != `ENS_VSEL_OFF);
      st_d.sw_lp[`ENS_SW_EXT_BIT] = asgv[0] && !pin && keepv[0]
                                    && (vsel[0] != `ENS_VSEL_OFF);
      st_d.ext_v   = asgv[0] ? vsel[0] : `ENS_VSEL_OFF;
      st_d.core1_v = asgv[1] ? vsel[1] : `ENS_VSEL_OFF;
      st_d.core2_v = asgv[2] ? vsel[2] : `ENS_VSEL_OFF;
      // Serial link off while any linear or switching supply is assigned
      st_d.link_off = (|st_q.cfg.lin_assign) || (|st_q.cfg.sw_assign[3:0]);
   end

   always_ff @(posedge MCLK_IN)
   begin
      if (!RSTN_IN)
      begin
         st_q <= '0;
      end
      else
      begin
         st_q <= st_d;
      end
   end

   assign PRDATA_OUT          = st_q.prdata;
   assign PREADY_OUT          = st_q.pready;
   assign PSLVERR_OUT         = st_q.pslverr;
   assign LIN_PIN_CTL_OUT     = st_q.lin_ctl;
   assign LIN_LP_OUT          = st_q.lin_lp;
   assign SW_PIN_CTL_OUT      = st_q.sw_ctl;
   assign SW_ON_OUT           = st_q.sw_on;
   assign SW_LP_OUT           = st_q.sw_lp;
   assign EXT_VSEL_OUT        = st_q.ext_v;
   assign CORE1_VSEL_OUT      = st_q.core1_v;
   assign CORE2_VSEL_OUT      = st_q.core2_v;
   assign SERIAL_LINK_OFF_OUT = st_q.link_off;

   // Linear on state, one internal flop per regulator
   logic [7:0] lin_on_q;
   generate
      for (genvar g = 0; g < 8; g++)
      begin : g_lin
         always_ff @(posedge MCLK_IN)
         begin
            if (!RSTN_IN)
            begin
               lin_on_q[g] <= 1'b0;
            end
            else
            begin
               lin_on_q[g] <= st_q.cfg.lin_assign[g] && pin;
            end
         end
      end
   endgenerate

   default clocking cb @(posedge MCLK_IN); endclocking
   default disable iff (!RSTN_IN);

   sequence s_write_sw;
      PSEL_IN && PENABLE_IN && !PREADY_OUT && PWRITE_IN && wr_ok
      && PADDR_IN == `ENS_SW_ASSIGN_ADDR;
   endsequence

   chk_lin_on_pin: assert property (lin_on_q == $past(st_q.cfg.lin_assign & {8{pin}}))
      else $error("linear on state wrong");
   chk_lin_lp_mode: assert property (##1 LIN_LP_OUT == ($past(st_q.cfg.lin_assign)
      & ~{8{$past(pin)}} & $past(SLEEP_KEEP_LINEAR_MASK_IN)))
      else $error("linear low-power wrong");
   chk_sw_reserved: assert property (s_write_sw |=> ##1 PRDATA_OUT[7:5] == 3'h0
      || !$past(acc))
      else $error("reserved bits not zero");
   chk_io_on_pin: assert property (st_q.cfg.sw_assign[0] && pin |=> SW_ON_OUT[0])
      else $error("io converter not on");
   chk_io_sleep_lp: assert property (st_q.cfg.sw_assign[0] && !pin |=>
      SW_LP_OUT[0] == $past(SLEEP_KEEP_SWITCHER_MASK_IN[0]))
      else $error("io converter sleep mode wrong");
   chk_ext_vsel_src: assert property (st_q.cfg.sw_assign[3] |=> EXT_VSEL_OUT ==
      ($past(pin) ? $past(vact[0]) : $past(vslp[0])))
      else $error("external voltage source wrong");
   chk_unassigned_none: assert property (st_q.cfg.sw_assign[3:0] == 4'h0 |=>
      SW_ON_OUT == 4'h0 && SW_LP_OUT == 4'h0)
      else $error("unassigned supply affected");
   chk_link_off_any: assert property ((|st_q.cfg.lin_assign) |=> SERIAL_LINK_OFF_OUT)
      else $error("serial link not disabled");
endmodule // ens_assign

// ### dv/ens_pin_host.sv
// Host-side model that drives the second enable pin
`timescale 1ns/1ps
module ens_pin_host
(
   // Clock
   input  wire logic mclk_in,
   // Enable pin
   output logic      pin_out
);
   initial pin_out = 1'b0;
   // Moves just after an edge, promptly or after idle cycles
   task automatic drive(input logic lvl, input int idle);
      begin
         repeat (idle) @(posedge mclk_in);
         pin_out <= lvl;
      end
   endtask
endmodule // ens_pin_host

// ### dv/tb_ens_assign.sv
// Self-checking bench for the enable-pin assignment registers
`timescale 1ns/1ps
`include "ens_regs.svh"
module tb_ens_assign;
   logic        clk = 1'b0;
   logic        rstn = 1'b0;
   logic        psel = 1'b0;
   logic        pen = 1'b0;
   logic        pwr = 1'b0;
   logic [11:0] pa = 12'h000;
   logic [31:0] pwd = 32'h0;
   logic [31:0] prd, rd;
   logic        prdy, perr, er, pin, xk = 1'b1, lnk;
   logic [7:0]  la, lk = 8'ha5, xa = 8'h21, xs = 8'h12, c1a = 8'h31, c1s = 8'h13;
   logic [7:0]  c2a = 8'h41, c2s = 8'h14, lctl, llp, xv, c1v, c2v;
   logic [4:0]  sa;
   logic [3:0]  sk = 4'h6, sctl, son, slp;
   int          n_fail = 0;
   int          checked = 0;

   ens_pin_host ens_pin_host_i (.mclk_in(clk), .pin_out(pin));
   ens_assign ens_assign_i (.MCLK_IN(clk), .RSTN_IN(rstn), .PSEL_IN(psel), .PENABLE_IN(pen),
      .PWRITE_IN(pwr), .PADDR_IN(pa), .PWDATA_IN(pwd), .PSTRB_IN(4'hf), .PRDATA_OUT(prd),
      .PREADY_OUT(prdy), .PSLVERR_OUT(perr), .SECOND_ENABLE_INPUT_IN(pin),
      .SLEEP_KEEP_LINEAR_MASK_IN(lk), .SLEEP_KEEP_SWITCHER_MASK_IN(sk),
      .EXTERNAL_CONVERTER_KEEP_BIT_IN(xk), .EXTERNAL_CONV_ACTIVE_VOLTAGE_IN(xa),
      .EXTERNAL_CONV_SLEEP_VOLTAGE_IN(xs), .CORE1_ACTIVE_VOLTAGE_IN(c1a),
      .CORE1_SLEEP_VOLTAGE_IN(c1s), .CORE2_ACTIVE_VOLTAGE_IN(c2a), .CORE2_SLEEP_VOLTAGE_IN(c2s),
      .LIN_PIN_CTL_OUT(lctl), .LIN_LP_OUT(llp), .SW_PIN_CTL_OUT(sctl), .SW_ON_OUT(son),
      .SW_LP_OUT(slp), .EXT_VSEL_OUT(xv), .CORE1_VSEL_OUT(c1v), .CORE2_VSEL_OUT(c2v),
      .SERIAL_LINK_OFF_OUT(lnk));

   initial
   begin
      forever #2.5 clk = ~clk;
   end

   task automatic complete_run();
      begin
         $display("checks %0d mismatches %0d", checked, n_fail);
         if (n_fail == 0 && checked > 0)
            $display("Run complete: PASS");
         else
            $display("Run complete: FAIL");
         $finish;
      end
   endtask

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      begin
         checked++;
         if (got !== exp)
         begin
            n_fail++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
         end
      end
   endtask

   // Setup, access until ready, then one idle cycle
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      begin
         psel <= 1'b1;
         pwr <= w;
         pa <= a;
         pwd <= d;
         @(posedge clk);
         pen <= 1'b1;
         for (n = 0; n < 20 && prdy !== 1'b1; n++)
            @(posedge clk);
         if (n == 20)
         begin
            n_fail++;
            complete_run();
         end
         rd = prd;
         er = perr;
         psel <= 1'b0;
         pen <= 1'b0;
         @(posedge clk);
      end
   endtask

   task automatic settle_and_expect();
      logic [3:0] lp;
      begin
         repeat (2) @(posedge clk);
         lp = {sa[3] & xk & (xs != 0), sa[2] & sk[2] & (c2s != 0), sa[1] & sk[1] & (c1s != 0),
               sa[0] & sk[0]} & {4{~pin}};
         check(lctl, la);
         check(llp, la & lk & {8{~pin}});
         check(sctl, sa[3:0]);
         check(son[0], sa[0] & pin);
         check(son[3:1], {sa[3] & ((pin ? xa : xs) != 8'h00),
                          sa[2] & ((pin ? c2a : c2s) != 8'h00),
                          sa[1] & ((pin ? c1a : c1s) != 8'h00)});
         check(ens_assign_i.lin_on_q, la & {8{pin}});
         check(slp, lp);
         check(xv, sa[3] ? (pin ? xa : xs) : 8'h00);
         check(c1v, sa[1] ? (pin ? c1a : c1s) : 8'h00);
         check(c2v, sa[2] ? (pin ? c2a : c2s) : 8'h00);
         check(lnk, |{la, sa[3:0]});
      end
   endtask

   initial
   begin
      la = 8'h00;
      sa = 5'h00;
      repeat (2) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      settle_and_expect();
      apb(1'b0, `ENS_LIN_ASSIGN_ADDR, 32'h0);
      check(rd, 32'h0);
      apb(1'b1, `ENS_SW_ASSIGN_ADDR, 32'hffff_ffff);
      apb(1'b0, `ENS_SW_ASSIGN_ADDR, 32'h0);
      check(rd, 32'h1f);
      apb(1'b1, `ENS_SW_ASSIGN_ADDR, 32'h0);
      apb(1'b0, 12'h049, 32'h0);
      check(er, 1'b1);
      check(rd, 32'h0);
      $display("test registers done");
      for (int i = 0; i < 8; i++)
      begin
         la = 8'h01 << i;
         apb(1'b1, `ENS_LIN_ASSIGN_ADDR, {24'h0, la});
         apb(1'b0, `ENS_LIN_ASSIGN_ADDR, 32'h0);
         check(rd, {24'h0, la});
         for (int p = 1; p >= 0; p--)
         begin
            ens_pin_host_i.drive(p[0], i % 2);
            settle_and_expect();
         end
      end
      la = 8'h00;
      apb(1'b1, `ENS_LIN_ASSIGN_ADDR, 32'h0);
      $display("test linear done");
      for (int j = 0; j < 4; j++)
      begin
         sa = (j < 3) ? 5'h0f : 5'h00;
         sk <= (j == 0) ? 4'h6 : 4'hf;
         xk <= j[0];
         xs <= (j == 2) ? 8'h00 : 8'h12;
         c1s <= (j == 2) ? 8'h00 : 8'h13;
         c2s <= (j == 2) ? 8'h00 : 8'h14;
         apb(1'b1, `ENS_SW_ASSIGN_ADDR, {27'h0, sa});
         for (int p = 1; p >= 0; p--)
         begin
            ens_pin_host_i.drive(p[0], j);
            settle_and_expect();
         end
      end
      $display("test switching done");
      complete_run();
   end
endmodule // tb_ens_assign
